/* File: hdl/cmp_out_pkg.sv */
package cmp_out_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // output characteristic encodings
  localparam logic [1:0] OUT_NONE  = 2'h0;
  localparam logic [1:0] OUT_GE    = 2'h1;
  localparam logic [1:0] OUT_LE    = 2'h2;
  localparam logic [1:0] OUT_PULSE = 2'h3;

  // main counting direction encodings
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_UP   = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;

  // maximum frequency selections
  localparam logic [2:0] FSEL_1K  = 3'h0;
  localparam logic [2:0] FSEL_2K  = 3'h1;
  localparam logic [2:0] FSEL_5K  = 3'h2;
  localparam logic [2:0] FSEL_10K = 3'h3;
  localparam logic [2:0] FSEL_30K = 3'h4;
  localparam logic [2:0] FSEL_60K = 3'h5;

  // interrupt cause bit positions
  localparam int unsigned IRQ_GOPEN  = 0;
  localparam int unsigned IRQ_GCLOSE = 1;
  localparam int unsigned IRQ_CMP    = 2;
  localparam int unsigned IRQ_OVF    = 3;
  localparam int unsigned IRQ_UNF    = 4;
  localparam int unsigned IRQ_W      = 5;

  // reset values
  localparam logic [1:0]       MODE_RST     = OUT_NONE;
  localparam logic [1:0]       MDIR_RST     = DIR_NONE;
  localparam logic [7:0]       PLEN_RST     = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST   = 5'h00;
  localparam logic [2:0]       FSEL_CNT_RST = FSEL_60K;
  localparam logic [2:0]       FSEL_LAT_RST = FSEL_10K;

  // shortest permissible pulse per setting, in ns
  localparam int unsigned T_MIN_1K_NS  = 400000;
  localparam int unsigned T_MIN_2K_NS  = 200000;
  localparam int unsigned T_MIN_5K_NS  = 80000;
  localparam int unsigned T_MIN_10K_NS = 40000;
  localparam int unsigned T_MIN_30K_NS = 13000;
  localparam int unsigned T_MIN_60K_NS = 6700;

  // least times, rounded up to whole cycles
  localparam int unsigned MIN_1K_CYC =
    (T_MIN_1K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_2K_CYC =
    (T_MIN_2K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_5K_CYC =
    (T_MIN_5K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_10K_CYC =
    (T_MIN_10K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_30K_CYC =
    (T_MIN_30K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_60K_CYC =
    (T_MIN_60K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pulse length step
  localparam int unsigned PULSE_STEP_NS = 2000000;
  localparam int unsigned PULSE_STEP_CYC = PULSE_STEP_NS / CLK_PERIOD_NS;

endpackage : cmp_out_pkg

/* File: hdl/pulse_filter.sv */
module pulse_filter (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        pin_i,
  input  wire logic [15:0] min_cyc_i,
  output logic             level_o
);

  logic        sync1_q;
  logic        sync2_q;
  logic        level_q;
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic        flip_w;

  // a change is taken only once it has stood for the minimum time
  assign flip_w = (sync2_q != level_q) && ((run_q + 16'h0001) >= min_cyc_i);
  assign run_d  = (sync2_q == level_q || flip_w) ? 16'h0000
                                                 : run_q + 16'h0001;
  assign level_o = level_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      run_q   <= 16'h0000;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      run_q   <= run_d;
      if (flip_w) begin
        level_q <= sync2_q;
      end
    end
  end

endmodule : pulse_filter

/* File: hdl/counter_compare_output_irq.sv */
module counter_compare_output_irq
  import cmp_out_pkg::*;
#(
  parameter int unsigned FILT_1K_CYC  = MIN_1K_CYC,
  parameter int unsigned FILT_2K_CYC  = MIN_2K_CYC,
  parameter int unsigned FILT_5K_CYC  = MIN_5K_CYC,
  parameter int unsigned FILT_10K_CYC = MIN_10K_CYC,
  parameter int unsigned TICK_CYC     = PULSE_STEP_CYC
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // counting core, same clock
  input  wire logic [31:0]      count_value_i,
  input  wire logic             count_step_i,
  input  wire logic             count_dir_up_i,
  input  wire logic             overflow_evt_i,
  input  wire logic             underflow_evt_i,
  input  wire logic [31:0]      compare_value_i,
  // configuration
  input  wire logic [1:0]       out_mode_i,
  input  wire logic [1:0]       main_dir_i,
  input  wire logic [7:0]       pulse_len_i,
  input  wire logic             plain_out_i,
  input  wire logic [IRQ_W-1:0] irq_en_i,
  input  wire logic [2:0]       fsel_count_i,
  input  wire logic [2:0]       fsel_latch_i,
  input  wire logic             software_gate_control_i,
  // pins
  input  wire logic             track_a_i,
  input  wire logic             track_b_i,
  input  wire logic             hardware_gate_input_i,
  input  wire logic             latch_i,
  // results
  output logic                  channel_out_o,
  output logic                  compare_status_flag_o,
  output logic                  hw_irq_o,
  output logic [IRQ_W-1:0]      irq_cause_o,
  output logic                  track_a_filt_o,
  output logic                  track_b_filt_o,
  output logic                  gate_filt_o,
  output logic                  latch_filt_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_TIMED, ST_HOLD} pulse_st_t;

  //////////////////////////////////////////////////////////////////////////
  // configuration, held with defined reset values

  logic [1:0]       mode_q;
  logic [1:0]       mdir_q;
  logic [7:0]       plen_q;
  logic             plain_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [2:0]       fsel_cnt_q;
  logic [2:0]       fsel_lat_q;
  logic             swg_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q     <= MODE_RST;
      mdir_q     <= MDIR_RST;
      plen_q     <= PLEN_RST;
      plain_q    <= 1'b0;
      irq_en_q   <= IRQ_EN_RST;
      fsel_cnt_q <= FSEL_CNT_RST;
      fsel_lat_q <= FSEL_LAT_RST;
      swg_q      <= 1'b0;
    end else begin
      mode_q     <= out_mode_i;
      mdir_q     <= main_dir_i;
      plen_q     <= pulse_len_i;
      plain_q    <= plain_out_i;
      irq_en_q   <= irq_en_i;
      fsel_cnt_q <= fsel_count_i;
      fsel_lat_q <= fsel_latch_i;
      swg_q      <= software_gate_control_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // input filtering; unknown selections fall back to the fastest setting

  logic [15:0] min_cnt_w;
  logic [15:0] min_lat_w;

  function automatic logic [15:0] min_for(input logic [2:0] sel);
    logic [15:0] r;
    r = 16'(MIN_60K_CYC);
    case (sel)
      FSEL_1K:  r = 16'(FILT_1K_CYC);
      FSEL_2K:  r = 16'(FILT_2K_CYC);
      FSEL_5K:  r = 16'(FILT_5K_CYC);
      FSEL_10K: r = 16'(FILT_10K_CYC);
      FSEL_30K: r = 16'(MIN_30K_CYC);
      default:  r = 16'(MIN_60K_CYC);
    endcase
    return r;
  endfunction : min_for

  assign min_cnt_w = min_for(fsel_cnt_q);
  assign min_lat_w = min_for(fsel_lat_q);

  logic ta_w;
  logic tb_w;
  logic gt_w;
  logic lt_w;
  pulse_filter u_filt_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (track_a_i),
    .min_cyc_i  (min_cnt_w),
    .level_o    (ta_w)
  );
  pulse_filter u_filt_b (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (track_b_i),
    .min_cyc_i  (min_cnt_w),
    .level_o    (tb_w)
  );
  pulse_filter u_filt_g (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (hardware_gate_input_i),
    .min_cyc_i  (min_cnt_w),
    .level_o    (gt_w)
  );
  pulse_filter u_filt_l (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (latch_i),
    .min_cyc_i  (min_lat_w),
    .level_o    (lt_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // comparison

  logic ge_w;
  logic le_w;
  logic eq_w;
  logic dir_ok_w;
  logic reach_w;

  assign ge_w = $signed(count_value_i) >= $signed(compare_value_i);
  assign le_w = $signed(count_value_i) <= $signed(compare_value_i);
  assign eq_w = count_value_i == compare_value_i;
  assign dir_ok_w = (mdir_q == DIR_UP)   ? count_dir_up_i :
                    (mdir_q == DIR_DOWN) ? !count_dir_up_i : 1'b1;
  // reaching means a counting step in the main direction that lands on the value
  assign reach_w = count_step_i && eq_w && dir_ok_w;

  //////////////////////////////////////////////////////////////////////////
  // pulse sequencer

  pulse_st_t   st_q;
  pulse_st_t   st_d;
  logic [17:0] tick_q;
  logic [17:0] tick_d;
  logic [7:0]  left_q;
  logic [7:0]  left_d;
  logic        start_w;
  logic        tick_w;

  assign start_w = (mode_q == OUT_PULSE) && (st_q == ST_IDLE) && reach_w;
  assign tick_w  = (tick_q == 18'(TICK_CYC - 1));

  always_comb begin
    st_d   = st_q;
    tick_d = tick_w ? 18'h00000 : tick_q + 18'h00001;
    left_d = left_q;
    case (st_q)
      ST_IDLE: begin
        if (start_w) begin
          // prescaler restarts with the output, so no phase error
          tick_d = 18'h00000;
          left_d = plen_q;
          st_d   = (plen_q == 8'h00) ? ST_HOLD : ST_TIMED;
        end
      end
      ST_TIMED: begin
        // further reaches are ignored here
        if (tick_w) begin
          left_d = left_q - 8'h01;
          if (left_q == 8'h01) begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (!eq_w) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (mode_q != OUT_PULSE) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= ST_IDLE;
      tick_q <= 18'h00000;
      left_q <= 8'h00;
    end else begin
      st_q   <= st_d;
      tick_q <= tick_d;
      left_q <= left_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output and compare status

  logic out_d;
  logic out_q;
  logic flag_d;
  logic flag_q;
  logic cond_w;
  logic cmp_trig_w;

  assign cond_w = (mode_q == OUT_GE) ? ge_w :
                  (mode_q == OUT_LE) ? le_w : 1'b0;
  assign out_d  = (mode_q == OUT_NONE)  ? plain_q :
                  (mode_q == OUT_PULSE) ? (st_d != ST_IDLE) : cond_w;
  assign flag_d = (mode_q == OUT_NONE) ? 1'b0 : out_d;
  // comparator triggers on the rise of its own condition
  assign cmp_trig_w = start_w || (cond_w && !flag_q);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q  <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      out_q  <= out_d;
      flag_q <= flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // hardware interrupts; this stage serves the gated channel

  logic             gt_prev_q;
  logic             g_rise_w;
  logic             g_fall_w;
  logic [IRQ_W-1:0] cause_d;
  logic [IRQ_W-1:0] cause_q;
  logic             irq_q;

  assign g_rise_w = gt_w && !gt_prev_q && swg_q;
  assign g_fall_w = !gt_w && gt_prev_q && swg_q;

  always_comb begin
    cause_d = '0;
    cause_d[IRQ_GOPEN]  = irq_en_q[IRQ_GOPEN] && g_rise_w;
    cause_d[IRQ_GCLOSE] = irq_en_q[IRQ_GCLOSE] && g_fall_w;
    cause_d[IRQ_CMP]    = irq_en_q[IRQ_CMP] && cmp_trig_w;
    cause_d[IRQ_OVF]    = irq_en_q[IRQ_OVF] && overflow_evt_i;
    cause_d[IRQ_UNF]    = irq_en_q[IRQ_UNF] && underflow_evt_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gt_prev_q <= 1'b0;
      cause_q   <= '0;
      irq_q     <= 1'b0;
    end else begin
      gt_prev_q <= gt_w;
      cause_q   <= cause_d;
      irq_q     <= |cause_d;
    end
  end

  assign channel_out_o         = out_q;
  assign compare_status_flag_o = flag_q;
  assign hw_irq_o              = irq_q;
  assign irq_cause_o           = cause_q;
  assign track_a_filt_o        = ta_w;
  assign track_b_filt_o        = tb_w;
  assign gate_filt_o           = gt_w;
  assign latch_filt_o          = lt_w;

  //////////////////////////////////////////////////////////////////////////
  // checks

  AST_NONE_PLAIN: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (mode_q == OUT_NONE) |=> (!flag_q && out_q == $past(plain_q)))
    else $error("no-comparison output wrong");

  AST_CMP_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ((mode_q == OUT_GE && ge_w) || (mode_q == OUT_LE && le_w))
      |=> (out_q && flag_q))
    else $error("comparator output not set");

  AST_PULSE_START: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (start_w && plen_q != 8'h00) |=> (out_q && st_q == ST_TIMED))
    else $error("pulse not started on reach");

  AST_WRONG_DIR: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (mode_q == OUT_PULSE && st_q == ST_IDLE && mdir_q == DIR_UP
      && count_step_i && !count_dir_up_i) |=> (st_q == ST_IDLE))
    else $error("pulse started against main direction");

  AST_TIMING_ALIGN: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(out_q) && st_q == ST_TIMED |-> (tick_q == 18'h00000))
    else $error("pulse timer not aligned to output");

  AST_NO_RETRIGGER: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (st_q == ST_TIMED && reach_w && !tick_w) |=> $stable(left_q))
    else $error("running pulse retriggered");

  AST_LEN_FROZEN: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (st_q == ST_TIMED && !tick_w && mode_q == OUT_PULSE)
      |=> (left_q == $past(left_q)))
    else $error("pulse length changed in flight");

  AST_HOLD_RELEASE: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (st_q == ST_HOLD && !eq_w) |=> !out_q)
    else $error("zero-length pulse not released");

  AST_GATE_RISE: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (irq_en_q[IRQ_GOPEN] && swg_q && $rose(gt_w))
      |=> (hw_irq_o && irq_cause_o[IRQ_GOPEN]))
    else $error("gate opening interrupt missing");

  AST_OVF_IRQ: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (irq_en_q[IRQ_OVF] && overflow_evt_i) |=> irq_cause_o[IRQ_OVF])
    else $error("overflow interrupt missing");

  AST_IRQ_OFF: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (irq_en_q == '0) |=> !hw_irq_o)
    else $error("interrupt while all disabled");

endmodule : counter_compare_output_irq

/* File: tb/pin_source.sv */
module pin_source (
  input  wire logic       core_clk_i,
  output logic      [3:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // bit 0 track a, bit 1 track b, bit 2 gate, bit 3 latch
  initial pins_o = 4'h0;

  // a level is held for whole cycles; glitches come only from a test
  // that asks for a width below the filter minimum
  task automatic drive(input logic [3:0] lvl, input int cyc);
    @(posedge core_clk_i);
    pins_o <= lvl;
    repeat (cyc) @(posedge core_clk_i);
  endtask : drive
endmodule : pin_source

/* File: tb/counter_compare_output_irq_bench.sv */
module counter_compare_output_irq_bench import cmp_out_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int F_CYC [4] = '{40, 30, 20, 10};
  localparam int TICK      = 8;
  localparam int LIMIT     = 20000;

  logic             core_clk_i;
  logic             rst_i;
  logic [31:0]      cnt;
  logic [31:0]      cmpv;
  logic             stp;
  logic             up;
  logic             ovf;
  logic             unf;
  logic [1:0]       mode;
  logic [1:0]       mdir;
  logic [7:0]       plen;
  logic             plain;
  logic             swg;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] cause;
  logic [IRQ_W-1:0] cause_acc;
  logic [2:0]       fc;
  logic [2:0]       fl;
  logic [3:0]       pins;
  logic [3:0]       filt;
  logic [3:0]       seen;
  logic             out;
  logic             flag;
  logic             irq;
  int               miscompares;
  int               checks;
  int               out_hi;
  int               irq_n;
  int               cyc;

  pin_source src_u (.core_clk_i(core_clk_i), .pins_o(pins));

  counter_compare_output_irq #(
    .FILT_1K_CYC(40), .FILT_2K_CYC(30), .FILT_5K_CYC(20),
    .FILT_10K_CYC(10), .TICK_CYC(TICK)
  ) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .count_value_i(cnt),
    .count_step_i(stp), .count_dir_up_i(up), .overflow_evt_i(ovf),
    .underflow_evt_i(unf), .compare_value_i(cmpv),
    .out_mode_i(mode), .main_dir_i(mdir), .pulse_len_i(plen),
    .plain_out_i(plain), .irq_en_i(irq_en), .fsel_count_i(fc),
    .fsel_latch_i(fl), .software_gate_control_i(swg),
    .track_a_i(pins[0]), .track_b_i(pins[1]),
    .hardware_gate_input_i(pins[2]), .latch_i(pins[3]),
    .channel_out_o(out), .compare_status_flag_o(flag), .hw_irq_o(irq),
    .irq_cause_o(cause), .track_a_filt_o(filt[0]),
    .track_b_filt_o(filt[1]), .gate_filt_o(filt[2]),
    .latch_filt_o(filt[3])
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle outputs are summed every edge so no pulse is missed
  always @(posedge core_clk_i) begin
    out_hi += int'(out);
    irq_n += int'(irq);
    cause_acc |= cause;
    seen |= filt;
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle

  // cleared off the sampling edge to avoid racing the accumulators
  task automatic clr();
    @(negedge core_clk_i);
    out_hi = 0;
    irq_n = 0;
    cause_acc = '0;
    seen = '0;
  endtask : clr

  task automatic setm(input logic [1:0] m, input logic [1:0] d,
                      input logic [7:0] l);
    @(posedge core_clk_i);
    mode <= m;
    mdir <= d;
    plen <= l;
    idle(2);
  endtask : setm

  task automatic step(input logic [31:0] v, input logic u);
    @(posedge core_clk_i);
    cnt <= v;
    up <= u;
    stp <= 1'b1;
    @(posedge core_clk_i);
    stp <= 1'b0;
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] c0;
    logic [IRQ_W-1:0] e;
    rst_i = 1'b1;
    cnt = 32'h0000_00C8;
    cmpv = 32'h0000_0064;
    {stp, up, ovf, unf, plain, swg} = 6'h00;
    mode = OUT_NONE;
    mdir = DIR_NONE;
    plen = 8'h00;
    irq_en = '0;
    fc = FSEL_10K;
    fl = FSEL_10K;
    {miscompares, checks, out_hi, irq_n, cyc} = '0;
    cause_acc = '0;
    seen = '0;
    idle(12);
    chk({out, flag, irq, cause}, '0);
    rst_i <= 1'b0;
    idle(2);
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk_i);
      plain <= p[0];
      idle(3);
      chk({flag, out}, {1'b0, p[0]});
    end
    $display("test plain output done");
    irq_en <= 5'h01 << IRQ_CMP;
    for (int i = 0; i < 2; i++) begin
      c0 = (i == 0) ? 32'h0000_0063 : 32'h0000_0065;
      @(posedge core_clk_i);
      cnt <= c0;
      mode <= (i == 0) ? OUT_GE : OUT_LE;
      idle(3);
      clr();
      for (int k = 0; k < 3; k++) begin
        @(posedge core_clk_i);
        cnt <= (k == 0) ? c0 : (k == 1) ? 32'h0000_0064 : 32'h0000_00C8 - c0;
        idle(3);
        chk({flag, out}, {2{k != 0}});
      end
      chk(irq_n, 1);
      chk(cause_acc, 5'h01 << IRQ_CMP);
    end
    // a negative compare value catches an unsigned comparison
    @(posedge core_clk_i);
    cmpv <= 32'hFFFF_FFF0;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      cnt <= (k == 0) ? 32'h0000_0005 : 32'hFFFF_FFE0;
      idle(3);
      chk({flag, out}, {2{k != 0}});
    end
    cmpv <= 32'h0000_0064;
    $display("test comparator done");
    setm(OUT_PULSE, DIR_NONE, 8'h01);
    clr();
    step(32'h0000_0064, 1'b1);
    step(32'h0000_0065, 1'b1);
    @(posedge core_clk_i);
    plen <= 8'h02;
    step(32'h0000_0064, 1'b1);
    idle(30);
    chk(out_hi, TICK);
    chk(irq_n, 1);
    clr();
    step(32'h0000_0065, 1'b1);
    step(32'h0000_0064, 1'b1);
    idle(40);
    chk(out_hi, 2 * TICK);
    $display("test pulse length done");
    for (int i = 0; i < 2; i++) begin
      setm(OUT_PULSE, (i == 0) ? DIR_UP : DIR_DOWN, 8'h01);
      step(32'h0000_0065, 1'b1);
      clr();
      step(32'h0000_0064, i[0]);
      step(32'h0000_0065, 1'b1);
      idle(20);
      chk(out_hi, 0);
      clr();
      step(32'h0000_0064, ~i[0]);
      idle(20);
      chk(out_hi, TICK);
    end
    $display("test main direction done");
    setm(OUT_PULSE, DIR_NONE, 8'h00);
    step(32'h0000_0065, 1'b1);
    step(32'h0000_0064, 1'b1);
    idle(20);
    chk(out, 1'b1);
    step(32'h0000_0065, 1'b1);
    idle(3);
    chk(out, 1'b0);
    $display("test zero length done");
    irq_en <= (5'h01 << IRQ_OVF) | (5'h01 << IRQ_UNF);
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? 5'h01 << IRQ_OVF : (i == 1) ? 5'h01 << IRQ_UNF : '0;
      if (i == 2) begin
        irq_en <= '0;
      end
      clr();
      @(posedge core_clk_i);
      ovf <= (i != 1);
      unf <= (i != 0);
      @(posedge core_clk_i);
      ovf <= 1'b0;
      unf <= 1'b0;
      idle(3);
      chk(irq_n, (i == 2) ? 0 : 1);
      chk(cause_acc, e);
    end
    $display("test limit events done");
    for (int f = 0; f < 4; f++) begin
      @(posedge core_clk_i);
      fc <= f[2:0];
      fl <= 3'(3 - f);
      idle(2);
      clr();
      // latch runs on its own setting; a held level of n cycles
      // is sampled n+1 times after the synchroniser
      src_u.drive(4'hF, F_CYC[f] - 4);
      src_u.drive(4'h0, 20);
      chk(seen, (F_CYC[f] - 3 >= F_CYC[3 - f]) ? 4'h8 : 4'h0);
      clr();
      src_u.drive(4'hF, 48);
      src_u.drive(4'h0, 48);
      chk(seen, 4'hF);
    end
    $display("test input filters done");
    irq_en <= (5'h01 << IRQ_GOPEN) | (5'h01 << IRQ_GCLOSE);
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk_i);
      swg <= s[0];
      idle(2);
      clr();
      src_u.drive(4'h4, 20);
      src_u.drive(4'h0, 20);
      chk(irq_n, 2 * s);
      chk(cause_acc, {5{s[0]}} & 5'h03);
    end
    $display("test gate interrupts done");
    end_of_test();
  end
endmodule : counter_compare_output_irq_bench
